//--- pkg/lras_pkg.sv
package lras_pkg;

    // ********************************************************************
    // Register map of the AHB-Lite slave (byte addresses)
    // ********************************************************************
    localparam logic [7:0]  REG_CTRL      = 8'h00;
    localparam logic [7:0]  REG_OSC_DIV   = 8'h04;
    localparam logic [7:0]  REG_STATUS    = 8'h08;
    localparam logic [7:0]  REG_SCROLL    = 8'h0c;

    // Field positions
    localparam int          CTRL_FONT6    = 0;
    localparam int          ST_BUSY       = 0;
    localparam int          ST_EXT        = 1;
    localparam int          ST_INC        = 2;
    localparam int          ST_SEL_LSB    = 4;
    localparam int          ST_AC_LSB     = 8;

    // ********************************************************************
    // Reset values
    // ********************************************************************
    localparam logic        RST_FONT6     = 1'b0;
    localparam logic        RST_EXT       = 1'b0;
    localparam logic        RST_INC       = 1'b1;
    localparam logic [6:0]  RST_AC        = 7'h00;

    // ********************************************************************
    // Timing: times in ns, oscillator ticks derived from reference rate
    // ********************************************************************
    localparam int          CLK_KHZ       = 250000;
    localparam int          FOSC_KHZ      = 160;
    localparam int          EXEC_NS       = 63000;
    localparam int          ADDR_UPDATE_DELAY_NS       = 9300;
    localparam int          EXEC_TICKS    = EXEC_NS * FOSC_KHZ / 1000000;
    localparam int          EXEC6_TICKS   = EXEC_TICKS * 6 / 5;
    localparam int          ADDR_UPDATE_DELAY_RAW      = ADDR_UPDATE_DELAY_NS * FOSC_KHZ / 1000000;
    localparam int          ADDR_UPDATE_DELAY_TICKS    = (ADDR_UPDATE_DELAY_RAW < 1) ? 1 : ADDR_UPDATE_DELAY_RAW;
    localparam int          OSC_DIV_DEF   = CLK_KHZ / FOSC_KHZ;

    // ********************************************************************
    // Types
    // ********************************************************************
    typedef enum logic [1:0] {SEL_DD, SEL_CG, SEL_SEG} lras_sel_t;

    typedef struct packed {
        logic       valid;  // One-cycle strobe
        logic       rd;     // 1 read, 0 write
        logic       rs;     // Register select
        logic [7:0] data;   // Instruction or write data
    } lras_instr_t;

    typedef struct packed {
        logic       valid;  // One-cycle strobe
        logic [7:0] data;   // Read answer
    } lras_resp_t;

endpackage : lras_pkg

//--- rtl/lras_core.sv
`timescale 1ns/1ps

module lras_core #(
    parameter int OSC_DIV_RST = lras_pkg::OSC_DIV_DEF  // hclk per osc tick
) (
    input  wire logic                  hclk,          // System clock
    input  wire logic                  hresetn,       // Async reset, low
    input  wire logic                  hsel,          // AHB slave select
    input  wire logic [31:0]           haddr,         // AHB address
    input  wire logic [1:0]            htrans,        // AHB transfer type
    input  wire logic                  hwrite,        // AHB write
    input  wire logic [2:0]            hsize,         // AHB size, word only
    input  wire logic [31:0]           hwdata,        // AHB write data
    input  wire logic                  hready,        // AHB bus ready
    output logic [31:0]                hrdata,        // AHB read data
    output logic                       hreadyout,     // AHB slave ready
    output logic                       hresp,         // AHB response
    input  wire lras_pkg::lras_instr_t instr,         // Decoded transfer
    input  wire logic [1:0]            scan_state,    // Key scan state
    input  wire logic [4:0]            key_scan_data, // Key scan column
    output lras_pkg::lras_resp_t       resp,          // Read answer
    output logic                       busy_flag,     // Executing
    output logic                       ext_select,    // Extension set
    output logic [1:0]                 partial_scroll_chars, // Scroll chars
    output logic [4:0]                 horiz_dot_scroll      // Dot scroll
);

    // ********************************************************************
    // Types, storage and state
    // ********************************************************************
    typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_ADDR_WAIT} lras_state_t;

    lras_state_t          state_q;
    logic [7:0]           dd_ram_q [64];
    logic [7:0]           cg_ram_q [64];
    logic [7:0]           seg_ram_q [16];
    lras_pkg::lras_sel_t  sel_q;
    logic [6:0]           ac_q;
    logic                 inc_q;
    logic                 ext_q;
    logic                 step_pend_q;
    logic [1:0]           ps_q;
    logic [4:0]           hds_q;
    logic                 font6_q;
    logic [15:0]          osc_div_q;
    logic [15:0]          div_cnt_q;
    logic [7:0]           tick_cnt_q;
    lras_pkg::lras_resp_t resp_q;
    logic                 ahb_pend_q;
    logic                 ahb_wr_q;
    logic [7:0]           ahb_addr_q;
    logic [31:0]          hrdata_q;
    logic                 hready_q;
    logic                 hresp_q;

    // Steps the counter within the width of the selected RAM
    function automatic logic [6:0] step_ac(input logic [6:0] ac,
                                           input logic       up);
        logic [6:0] nxt;
        nxt = up ? 7'(ac + 7'h01) : 7'(ac - 7'h01);
        step_ac = {1'b0, nxt[5:0]};
    endfunction : step_ac

    // ********************************************************************
    // Oscillator tick from hclk; rate set by software
    // ********************************************************************
    wire osc_tick = (div_cnt_q >= 16'(osc_div_q - 16'h0001));

    // Divider runs free so execution time scales with its period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt_q <= 16'h0000;
        end else begin
            div_cnt_q <= osc_tick ? 16'h0000 : 16'(div_cnt_q + 16'h0001);
        end
    end

    // ********************************************************************
    // Instruction decode
    // ********************************************************************
    // Taking follows the reported flag, so no instruction or RAM access is taken while
    // the host still reads busy_flag as 1 after execution has ended
    wire       can_take  = !busy_flag;
    wire [7:0] d         = instr.data;
    wire       wr_ins    = instr.valid && !instr.rd && !instr.rs;
    wire       take_ins  = wr_ins && can_take;
    wire       take_bf   = instr.valid && instr.rd && !instr.rs;
    wire       take_wram = instr.valid && !instr.rd && instr.rs && can_take;
    wire       take_rram = instr.valid && instr.rd && instr.rs && can_take;

    // Same opcode bits decode differently per extension state
    wire       op_dd     = take_ins && !ext_q && (d[7:6] == 2'b10);
    wire       op_cg     = take_ins && !ext_q && (d[7:6] == 2'b01);
    wire       op_scroll = take_ins && ext_q && d[7];
    wire       op_seg    = take_ins && ext_q && (d[7:4] == 4'b0100);
    wire       op_fset   = take_ins && (d[7:5] == 3'b001);
    wire       op_entry  = take_ins && (d[7:2] == 6'b000001);
    wire       start     = take_ins || take_wram || take_rram;
    wire       ram_acc   = take_wram || take_rram;
    wire       do_step   = ram_acc && (sel_q != lras_pkg::SEL_SEG);


    // A step still waiting is applied before a new access uses the counter
    wire [6:0] ac_now    = step_pend_q ? step_ac(ac_q, inc_q) : ac_q;
    wire [5:0] idx6      = ac_now[5:0];
    wire [3:0] idx4      = ac_now[3:0];


    // Execution length in osc ticks, longer with the six-dot font
    wire [7:0] exec_len  = font6_q ? 8'(lras_pkg::EXEC6_TICKS)
                                   : 8'(lras_pkg::EXEC_TICKS);
    wire [7:0] addr_update_delay_len  = 8'(lras_pkg::ADDR_UPDATE_DELAY_TICKS);

    // Read path follows the RAM that was addressed last

    wire [7:0] ram_rd    = (sel_q == lras_pkg::SEL_DD)  ? dd_ram_q[idx6] :
                           (sel_q == lras_pkg::SEL_CG)  ? cg_ram_q[idx6] :
                                                          seg_ram_q[idx4];

    // Final osc tick of the count now loaded
    wire       cnt_done  = osc_tick && (tick_cnt_q == 8'h01);

    // ********************************************************************
    // Execution sequencer: busy, then the delayed counter update
    // ********************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q    <= ST_IDLE;
            tick_cnt_q <= 8'h00;
        end else begin
            case (state_q)
                ST_IDLE, ST_ADDR_WAIT: begin
                    if (start) begin
                        state_q    <= ST_BUSY;
                        tick_cnt_q <= exec_len;
                    end else if (state_q == ST_ADDR_WAIT && cnt_done) begin
                        state_q    <= ST_IDLE;
                    end else if (osc_tick && tick_cnt_q != 8'h00) begin
                        tick_cnt_q <= 8'(tick_cnt_q - 8'h01);
                    end
                end
                ST_BUSY: begin
                    if (cnt_done) begin
                        // Busy drops; a pending counter step follows later
                        state_q    <= step_pend_q ? ST_ADDR_WAIT : ST_IDLE;
                        tick_cnt_q <= addr_update_delay_len;
                    end else if (osc_tick) begin
                        tick_cnt_q <= 8'(tick_cnt_q - 8'h01);
                    end
                end
                default: begin
                    state_q    <= ST_IDLE;
                    tick_cnt_q <= 8'h00;
                end
            endcase
        end
    end

    // ********************************************************************
    // Address counter, RAM selection and mode bits
    // ********************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ac_q        <= lras_pkg::RST_AC;
            sel_q       <= lras_pkg::SEL_DD;
            step_pend_q <= 1'b0;
            inc_q       <= lras_pkg::RST_INC;
            ext_q       <= lras_pkg::RST_EXT;
        end else begin
            if (op_dd) begin
                ac_q        <= {1'b0, d[5:0]};
                sel_q       <= lras_pkg::SEL_DD;
                step_pend_q <= 1'b0;
            end else if (op_cg) begin
                ac_q        <= {1'b0, d[5:0]};
                sel_q       <= lras_pkg::SEL_CG;
                step_pend_q <= 1'b0;
            end else if (op_seg) begin
                ac_q        <= {3'b000, d[3:0]};
                sel_q       <= lras_pkg::SEL_SEG;
                step_pend_q <= 1'b0;
            end else if (ram_acc) begin
                ac_q        <= ac_now;
                step_pend_q <= do_step;
            end else if (step_pend_q && state_q == ST_ADDR_WAIT
                         && cnt_done) begin
                ac_q        <= step_ac(ac_q, inc_q);
                step_pend_q <= 1'b0;
            end else if (step_pend_q && start) begin
                ac_q        <= ac_now;
                step_pend_q <= 1'b0;
            end

            // Mode bits change only on their own instructions
            if (op_fset) begin
                ext_q <= d[2];
            end
            if (op_entry) begin
                inc_q <= d[1];
            end
        end
    end

    // Scroll settings, only in the extension set
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ps_q  <= 2'b00;
            hds_q <= 5'b00000;
        end else if (op_scroll) begin
            ps_q  <= d[6:5];
            hds_q <= d[4:0];
        end
    end

    // ********************************************************************
    // RAM storage, written at the current address
    // ********************************************************************
    // No reset on storage; contents are undefined until written
    always_ff @(posedge hclk) begin
        if (take_wram) begin
            case (sel_q)
                lras_pkg::SEL_DD:  dd_ram_q[idx6]  <= d;
                lras_pkg::SEL_CG:  cg_ram_q[idx6]  <= d;
                lras_pkg::SEL_SEG: seg_ram_q[idx4] <= d;
                default: ;
            endcase
        end
    end

    // ********************************************************************
    // Read answers to the transfer logic
    // ********************************************************************
    // Status read never waits on busy; a RAM read is ignored while busy
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            resp_q <= '0;
        end else begin
            resp_q.valid <= take_bf || take_rram;
            if (take_bf) begin
                resp_q.data <= {busy_flag, scan_state, key_scan_data};
            end else if (take_rram) begin
                resp_q.data <= ram_rd;
            end
        end
    end

    // ********************************************************************
    // AHB-Lite slave: one wait state, registered answer
    // ********************************************************************
    wire ahb_take = hsel && htrans[1] && hready;

    // Counter field may lag busy_flag by the late step of a RAM access
    wire [31:0] status_word = {16'h0000, 1'b0, ac_q,
                               2'b00, sel_q, 1'b0,
                               inc_q, ext_q, busy_flag};
    wire [31:0] reg_rd =
        (ahb_addr_q == lras_pkg::REG_CTRL)    ? {31'h0, font6_q} :
        (ahb_addr_q == lras_pkg::REG_OSC_DIV) ? {16'h0, osc_div_q} :
        (ahb_addr_q == lras_pkg::REG_STATUS)  ? status_word :
        (ahb_addr_q == lras_pkg::REG_SCROLL)  ? {25'h0, ps_q, hds_q} :
                                                32'h0000_0000;

    // Address phase captured; data phase one cycle later
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_pend_q <= 1'b0;
            ahb_wr_q   <= 1'b0;
            ahb_addr_q <= 8'h00;
            hready_q   <= 1'b1;
            hrdata_q   <= 32'h0000_0000;
            hresp_q    <= 1'b0;
        end else begin
            hresp_q <= 1'b0;
            if (ahb_pend_q) begin
                ahb_pend_q <= 1'b0;
                hready_q   <= 1'b1;
                hrdata_q   <= ahb_wr_q ? 32'h0000_0000 : reg_rd;
            end else if (ahb_take) begin
                ahb_pend_q <= 1'b1;
                ahb_wr_q   <= hwrite;
                ahb_addr_q <= haddr[7:0];
                hready_q   <= 1'b0;
            end
        end
    end

    // Register writes land in the first data-phase cycle, the wait state
    wire wr_ctrl = ahb_pend_q && ahb_wr_q
                   && (ahb_addr_q == lras_pkg::REG_CTRL);
    wire wr_div  = ahb_pend_q && ahb_wr_q
                   && (ahb_addr_q == lras_pkg::REG_OSC_DIV);

    // Font and oscillator rate steer the execution timing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            font6_q   <= lras_pkg::RST_FONT6;
            osc_div_q <= 16'(OSC_DIV_RST);
        end else begin
            if (wr_ctrl) begin
                font6_q <= hwdata[lras_pkg::CTRL_FONT6];
            end
            if (wr_div) begin
                // Zero would stretch the tick to 65536 cycles; held at one instead
                osc_div_q <= (hwdata[15:0] == 16'h0000) ? 16'h0001
                                                        : hwdata[15:0];
            end
        end
    end

    // ********************************************************************
    // Outputs straight from flip-flops
    // ********************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            busy_flag <= 1'b0;
        end else begin
            busy_flag <= (state_q == ST_BUSY) || start;
        end
    end

    assign hrdata               = hrdata_q;
    assign hreadyout            = hready_q;
    assign hresp                = hresp_q;
    assign resp                 = resp_q;
    assign ext_select           = ext_q;
    assign partial_scroll_chars = ps_q;
    assign horiz_dot_scroll     = hds_q;

endmodule : lras_core

//--- verif/lras_core_sva.sv
`timescale 1ns/1ps
module lras_core_sva #(
    parameter int OSC_DIV_RST = 4  // Reset divider
) (
    input wire logic                  hclk,          // Clock
    input wire logic                  hresetn,       // Reset, low
    input wire logic                  hsel,          // Select
    input wire logic [31:0]           haddr,         // Address
    input wire logic [1:0]            htrans,        // Transfer type
    input wire logic                  hwrite,        // Write
    input wire logic [2:0]            hsize,         // Size
    input wire logic [31:0]           hwdata,        // Write data
    input wire logic                  hready,        // Bus ready
    input wire logic [31:0]           hrdata,        // Read data
    input wire logic                  hreadyout,     // Slave ready
    input wire logic                  hresp,         // Response
    input wire lras_pkg::lras_instr_t instr,         // Instruction
    input wire logic [1:0]            scan_state,    // Scan state
    input wire logic [4:0]            key_scan_data, // Scan data
    input wire lras_pkg::lras_resp_t  resp,          // Answer
    input wire logic                  busy_flag,     // Busy
    input wire logic                  ext_select,    // Extension
    input wire logic [1:0]            partial_scroll_chars, // Chars
    input wire logic [4:0]            horiz_dot_scroll      // Dots
);
    // ****************************************************************
    // Helper logic
    // ****************************************************************
    // Bound holds only while the divider never rises above reset value
    localparam int MAXB = 12 * OSC_DIV_RST + 2;
    logic [15:0] busy_cnt_q;
    wire stat_rd  = instr.valid && instr.rd && !instr.rs;
    wire exec_req = instr.valid && !stat_rd && !busy_flag;
    wire ins_wr   = exec_req && !instr.rd && !instr.rs;
    // Length of the current busy period
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) busy_cnt_q <= 16'h0000;
        else if (busy_flag) busy_cnt_q <= busy_cnt_q + 16'h0001;
        else busy_cnt_q <= 16'h0000;
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // ****************************************************************
    // Assertions
    // ****************************************************************
    a_ahb_wait: assert property (hsel && htrans[1] && hready
        |=> !hreadyout ##1 hreadyout) else $error("wait state wrong");
    a_resp_okay: assert property (hresp == 1'b0) else $error("not OKAY");
    a_status_ans: assert property (stat_rd |=> resp.valid &&
        resp.data == {$past(busy_flag), $past(scan_state),
        $past(key_scan_data)}) else $error("status answer wrong");
    a_busy_start: assert property (exec_req |=> busy_flag)
        else $error("busy did not rise");
    a_busy_refuse: assert property (instr.valid && !stat_rd &&
        busy_flag |=> !resp.valid) else $error("busy request answered");
    a_ram_read: assert property (exec_req && instr.rd
        |=> resp.valid) else $error("no ram read answer");
    a_scroll_load: assert property (ins_wr && ext_select &&
        instr.data[7] |=> partial_scroll_chars == $past(instr.data[6:5])
        && horiz_dot_scroll == $past(instr.data[4:0]))
        else $error("scroll not loaded");
    a_ext_sel: assert property (ins_wr && instr.data[7:5] == 3'b001
        |=> ext_select == $past(instr.data[2])) else $error("ext wrong");
    a_busy_len: assert property (busy_flag
        |-> busy_cnt_q < MAXB) else $error("busy too long");
endmodule : lras_core_sva
bind lras_core lras_core_sva #(.OSC_DIV_RST(OSC_DIV_RST)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .instr(instr), .scan_state(scan_state),
    .key_scan_data(key_scan_data), .resp(resp), .busy_flag(busy_flag),
    .ext_select(ext_select), .partial_scroll_chars(partial_scroll_chars),
    .horiz_dot_scroll(horiz_dot_scroll));

//--- verif/lras_core_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
module lras_core_tb;
    localparam int DIV = 4;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata;
    logic [1:0] htrans = 2'b00, scan_state = 2'b00, partial_scroll_chars;
    logic [2:0] hsize = 3'h2;
    logic [4:0] key_scan_data = 5'h00, horiz_dot_scroll;
    logic hready, hreadyout, hresp, busy_flag, ext_select, v;
    logic [7:0] r;
    logic [31:0] d;
    int n_fail = 0, cmp_count = 0, n;
    lras_pkg::lras_instr_t instr;
    lras_pkg::lras_resp_t  resp;
    assign hready = hreadyout;
    always #2 hclk = ~hclk;
    lras_core #(.OSC_DIV_RST(DIV)) uut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .instr(instr),
        .scan_state(scan_state), .key_scan_data(key_scan_data),
        .resp(resp), .busy_flag(busy_flag), .ext_select(ext_select),
        .partial_scroll_chars(partial_scroll_chars),
        .horiz_dot_scroll(horiz_dot_scroll));
    lras_host host (.hclk(hclk), .instr(instr), .resp(resp),
        .busy_flag(busy_flag));
    // ****************************************************************
    // Bus tasks and helpers
    // ****************************************************************
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] w);
        @(posedge hclk);
        {hsel, htrans, haddr, hwrite} <= {1'b1, 2'b10, 24'h0, a, wr};
        do @(posedge hclk); while (!hreadyout);
        {hsel, htrans, hwdata} <= {1'b0, 2'b00, w};
        do @(posedge hclk); while (!hreadyout);
        d = hrdata;
    endtask : ahb
    function automatic logic [31:0] st(input logic [6:0] ac,
        input logic [1:0] sel, input logic inc, input logic ext);
        st = {17'h0, ac, 2'b00, sel, 1'b0, inc, ext, 1'b0};
    endfunction : st
    // Busy length of one entry mode instruction, in clock cycles
    task meas(input int ticks, input int dv);
        host.op(1'b0, 1'b0, 8'h06, 1'b1, r, v);
        n = 1;
        while (busy_flag) begin @(posedge hclk); n++; end
        `CHK("busy_len", 1'b1, n >= (ticks-1)*dv-1 && n <= ticks*dv+3)
    endtask : meas
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task t_regs();
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("status", st(0,0,1,0), d)
        ahb(1'b0, lras_pkg::REG_OSC_DIV, 0); `CHK("div", DIV, d)
        ahb(1'b0, lras_pkg::REG_SCROLL, 0); `CHK("scroll", 32'h0, d)
        ahb(1'b1, lras_pkg::REG_STATUS, 32'hffffffff);
        ahb(1'b1, 8'h20, 32'hffffffff); ahb(1'b0, 8'h20, 0);
        `CHK("unmapped", 32'h0, d)
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("status_ro", st(0,0,1,0), d)
    endtask : t_regs
    task t_ram();
        host.op(1'b0, 1'b0, 8'h85, 1'b1, r, v);
        host.op(1'b0, 1'b1, 8'ha5, 1'b1, r, v);
        host.op(1'b0, 1'b1, 8'h3c, 1'b1, r, v); host.settle();
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("ac_up", st(7,0,1,0), d)
        host.op(1'b0, 1'b0, 8'h85, 1'b1, r, v);
        host.op(1'b1, 1'b1, 8'h00, 1'b1, r, v); `CHK("rd0", 8'ha5, r)
        host.op(1'b1, 1'b1, 8'h00, 1'b1, r, v); `CHK("rd1", 8'h3c, r)
        host.op(1'b0, 1'b0, 8'h04, 1'b1, r, v);
        host.op(1'b0, 1'b0, 8'h86, 1'b1, r, v);
        host.op(1'b1, 1'b1, 8'h00, 1'b1, r, v); host.settle();
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("ac_dn", st(5,0,0,0), d)
        host.op(1'b0, 1'b0, 8'h06, 1'b1, r, v);
        host.op(1'b0, 1'b0, 8'h42, 1'b1, r, v);
        host.op(1'b0, 1'b1, 8'h5a, 1'b1, r, v); host.settle();
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("cg", st(3,1,1,0), d)
        host.op(1'b0, 1'b0, 8'h42, 1'b1, r, v);
        host.op(1'b1, 1'b1, 8'h00, 1'b1, r, v); `CHK("cg_rd", 8'h5a, r)
    endtask : t_ram
    task t_status();
        @(posedge hclk);
        {scan_state, key_scan_data} <= 7'h55;
        host.op(1'b1, 1'b0, 8'h00, 1'b1, r, v); `CHK("stat", 9'h155, {v, r})
        host.op(1'b0, 1'b0, 8'h90, 1'b1, r, v);
        host.op(1'b0, 1'b1, 8'h77, 1'b1, r, v);
        host.op(1'b1, 1'b0, 8'h00, 1'b0, r, v); `CHK("stat_b", 9'h1d5, {v, r})
        host.op(1'b1, 1'b1, 8'h00, 1'b0, r, v); `CHK("refuse", 1'b0, v)
        host.op(1'b0, 1'b0, 8'h80, 1'b0, r, v); host.settle();
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("ignored", st(7'h11,0,1,0), d)
        host.op(1'b1, 1'b0, 8'h00, 1'b1, r, v); `CHK("stat_i", 8'h55, r)
    endtask : t_status
    task t_ext();
        host.op(1'b0, 1'b0, 8'h24, 1'b1, r, v); host.settle();
        `CHK("ext_on", 1'b1, ext_select)
        host.op(1'b0, 1'b0, 8'hb7, 1'b1, r, v); host.settle();
        `CHK("scroll", 7'h37, {partial_scroll_chars, horiz_dot_scroll})
        ahb(1'b0, lras_pkg::REG_SCROLL, 0); `CHK("scroll_reg", 32'h37, d)
        host.op(1'b0, 1'b0, 8'h43, 1'b1, r, v);
        host.op(1'b0, 1'b1, 8'h99, 1'b1, r, v); host.settle();
        ahb(1'b0, lras_pkg::REG_STATUS, 0); `CHK("seg", st(3,2,1,1), d)
        host.op(1'b1, 1'b1, 8'h00, 1'b1, r, v); `CHK("seg_rd", 8'h99, r)
        host.op(1'b0, 1'b0, 8'h20, 1'b1, r, v); host.settle();
        `CHK("ext_off", 1'b0, ext_select)
    endtask : t_ext
    task t_timing();
        meas(10, DIV);
        ahb(1'b1, lras_pkg::REG_CTRL, 32'h1); meas(12, DIV);
        ahb(1'b0, lras_pkg::REG_CTRL, 0); `CHK("font6", 32'h1, d)
        ahb(1'b1, lras_pkg::REG_OSC_DIV, 0);
        ahb(1'b0, lras_pkg::REG_OSC_DIV, 0);
        `CHK("div_min", 32'h1, d)
        ahb(1'b1, lras_pkg::REG_OSC_DIV, 32'h2); meas(12, 2);
        ahb(1'b1, lras_pkg::REG_CTRL, 32'h0); meas(10, 2);
        ahb(1'b1, lras_pkg::REG_OSC_DIV, DIV);
    endtask : t_timing
    task report_and_stop();
        $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : report_and_stop
    // Watchdog sized well past the expected few thousand cycles
    initial begin
        #200000;
        n_fail++;
        $display("[FAIL] watchdog exp done got timeout");
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_ram();
        t_status();
        t_ext();
        t_timing();
        report_and_stop();
    end
endmodule : lras_core_tb

//--- verif/lras_host.sv
`timescale 1ns/1ps
module lras_host (
    input  wire logic                  hclk,      // Clock
    output lras_pkg::lras_instr_t      instr,     // Instruction out
    input  wire lras_pkg::lras_resp_t  resp,      // Answer in
    input  wire logic                  busy_flag  // Busy in
);
    initial instr = '0;
    // Waits out busy plus the late counter step before going on
    task settle();
        @(posedge hclk);
        while (busy_flag) @(posedge hclk);
        repeat (12) @(posedge hclk);
    endtask : settle
    // One instruction; wt 0 lets a test issue one into a busy device
    task op(input logic rd, input logic rs, input logic [7:0] d,
            input bit wt, output logic [7:0] r, output logic v);
        if (wt) settle();
        @(posedge hclk);
        instr <= '{1'b1, rd, rs, d};
        @(posedge hclk);
        instr.valid <= 1'b0;
        @(posedge hclk);
        r = resp.data;
        v = resp.valid;
    endtask : op
endmodule : lras_host
